// ### adcr_pkg.sv
// Shared constants of the converter output-coding and calibration link.
// Assumes both ends run from the same 25 MHz system clock rate.
package adcr_pkg;
  // ----------------------------------------------------------------
  // Output coding
  // ----------------------------------------------------------------
  localparam int          CODE_W      = 20;
  localparam logic [19:0] CODE_POS_FS = 20'h70000;
  localparam logic [19:0] CODE_NEG_FS = 20'h90000;
  localparam logic [19:0] CODE_ZERO   = 20'h00000;
  localparam logic [19:0] CODE_MAX    = 20'h7FFFF;
  localparam logic [19:0] CODE_MIN    = 20'h80000;
  localparam logic [19:0] OVF_HI      = 20'h70000;
  localparam logic [19:0] OVF_LO      = 20'h82FFF;
  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int CLK_NS      = 40;
  localparam int SCLK_NS     = 320;
  localparam int SCLK_HALF   = SCLK_NS / (2 * CLK_NS);
  localparam int SLOT_BITS   = 32;
  localparam int FRAME_BITS  = 2 * SLOT_BITS;
  localparam int CLIP_FRAMES = 4096;
  localparam int CAL_FRAMES  = 4;
  // Hold of the sleep/reset line, longer than two sample periods
  localparam int RST_HOLD_NS  = 45000;
  localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------------------------------
  // Controller register map (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LEFT   = 4'h8;
  localparam logic [3:0] REG_RIGHT  = 4'hC;
  localparam int CTRL_SLEEP  = 0;
  localparam int CTRL_CALOFF = 1;
  localparam int CTRL_PULSE  = 2;
  localparam int ST_CAL      = 0;
  localparam int ST_LCLIP    = 1;
  localparam int ST_RCLIP    = 2;
  localparam int ST_RESET    = 3;
  localparam int ST_NEW      = 4;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;
endpackage

// ### adcr_link_if.sv
// Serial output link between the converter filter end and its controller.
// Assumes the bench resolves no tristates: every wire has one driver.
`timescale 1ns/100ps
interface adcr_link_if;
  logic sclk;                 // Bit clock, made by the filter end
  logic lrck;                 // High during the left slot
  logic sdata;                // Serial data, MSB first
  logic cal_active;           // Offset calibration running
  logic left_clip_flag;       // Left overflow hold
  logic right_clip_flag;      // Right overflow hold
  logic sleep_reset_n_in;     // Power-down / reset, active low
  logic offset_correction_off_in; // High disables calibration

  modport dev (
    output sclk, lrck, sdata, cal_active, left_clip_flag, right_clip_flag,
    input  sleep_reset_n_in, offset_correction_off_in
  );
  modport ctl (
    input  sclk, lrck, sdata, cal_active, left_clip_flag, right_clip_flag,
    output sleep_reset_n_in, offset_correction_off_in
  );
endinterface

// ### adcr_dev.sv
// Filter-side end: output coding, overflow flags, offset calibration,
// power-down/reset handling and the master serial output port.
// Assumes filtered sample pairs arrive on the user side as 20-bit codes.
`timescale 1ns/100ps

// Functional notes
// - Samples are 20-bit two's complement codes
// - Full scale maps to 70000H, 90000H, zero 00000H
// - Overflow above 70000H or below 82FFFH
// - Calibration-active output drives input grounding switch
// - Calibration starts on sleep/reset line release
// - Stored offset covers modulator plus input stage
// - Controller applies reset after power-up
// - Controller resets after mode or clock changes
// - Reset held low beyond two sample periods
// - System clock must run without interruption
// - Zero-input word stored, subtracted from later samples
// - During calibration flag high, data forced low
// - Overflow flag holds 4096 sample periods
// - Offset subtracted only while correction enabled
module adcr_dev #(
  parameter int W         = adcr_pkg::CODE_W,
  parameter int DEPTH     = 2,
  parameter int HOLD      = adcr_pkg::CLIP_FRAMES,
  parameter int CAL_LEN   = adcr_pkg::CAL_FRAMES
) (
  input  wire logic         MCLK,      // System clock
  input  wire logic         RST,       // Synchronous reset, active high
  input  wire logic         CE,        // Clock enable
  input  wire logic [W-1:0] IN_LEFT,   // Left filtered code
  input  wire logic [W-1:0] IN_RIGHT,  // Right filtered code
  input  wire logic         IN_VALID,  // Pair offered
  output logic              IN_READY,  // Buffer can take a pair
  adcr_link_if.dev          link       // Serial output port
);
  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic clip(input logic [W-1:0] c);
    clip = ($signed(c) > $signed(adcr_pkg::OVF_HI)) ||
           ($signed(c) < $signed(adcr_pkg::OVF_LO));
  endfunction

  // Saturating subtract keeps the code inside its 20-bit span
  function automatic logic [W-1:0] corr(input logic [W-1:0] c,
                                        input logic [W-1:0] o);
    logic signed [W:0] d;
    d = $signed({c[W-1], c}) - $signed({o[W-1], o});
    if (d[W] != d[W-1])
      corr = d[W] ? adcr_pkg::CODE_MIN : adcr_pkg::CODE_MAX;
    else
      corr = d[W-1:0];
  endfunction

  typedef enum logic [1:0] {ADCR_SLEEP, ADCR_CAL, ADCR_RUN} adcr_state_e;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] slp_sync_reg;
  logic [1:0] off_sync_reg;
  logic       slp_last_reg;
  logic       awake;
  logic       cal_off;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      slp_sync_reg <= 2'h0;
      off_sync_reg <= 2'h0;
      slp_last_reg <= 1'b0;
    end
    else if (CE)
    begin
      slp_sync_reg <= {slp_sync_reg[0], link.sleep_reset_n_in};
      off_sync_reg <= {off_sync_reg[0], link.offset_correction_off_in};
      slp_last_reg <= slp_sync_reg[1];
    end
  end
  assign awake   = slp_sync_reg[1];
  assign cal_off = off_sync_reg[1];

  // ----------------------------------------------------------------
  // Two-entry input buffer
  // ----------------------------------------------------------------
  logic [2*W-1:0]           buf_mem [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr_reg;
  logic [$clog2(DEPTH)-1:0] rd_ptr_reg;
  logic [$clog2(DEPTH):0]   cnt_reg;
  logic                     push;
  logic                     pop;
  logic                     frame_tick;

  assign push = IN_VALID && IN_READY;
  assign pop  = frame_tick && (cnt_reg != '0);

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
      IN_READY   <= 1'b0;
    end
    else if (CE)
    begin
      if (push)
      begin
        buf_mem[wr_ptr_reg] <= {IN_LEFT, IN_RIGHT};
        wr_ptr_reg <= (wr_ptr_reg == $clog2(DEPTH)'(DEPTH - 1)) ?
                      '0 : wr_ptr_reg + 1'b1;
      end
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == $clog2(DEPTH)'(DEPTH - 1)) ?
                      '0 : rd_ptr_reg + 1'b1;
      cnt_reg  <= cnt_reg + {{$clog2(DEPTH){1'b0}}, push}
                          - {{$clog2(DEPTH){1'b0}}, pop};
      // Ready from a flop, set from the next count; low only in reset or while the buffer holds DEPTH pairs
      IN_READY <= (cnt_reg + {{$clog2(DEPTH){1'b0}}, push}
                   - {{$clog2(DEPTH){1'b0}}, pop})
                  < ($clog2(DEPTH)+1)'(DEPTH);
    end
  end

  // ----------------------------------------------------------------
  // Bit clock divider and slot counter
  // ----------------------------------------------------------------
  logic [7:0] div_reg;
  logic       sclk_reg;
  logic [5:0] bit_reg;
  logic       fall;

  assign fall       = (div_reg == 8'(adcr_pkg::SCLK_HALF - 1)) && sclk_reg;
  assign frame_tick = fall && (bit_reg == 6'(adcr_pkg::FRAME_BITS - 1));

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      div_reg  <= 8'h00;
      sclk_reg <= 1'b0;
      bit_reg  <= 6'(adcr_pkg::FRAME_BITS - 1);
    end
    else if (CE)
    begin
      if (div_reg == 8'(adcr_pkg::SCLK_HALF - 1))
      begin
        div_reg  <= 8'h00;
        sclk_reg <= ~sclk_reg;
      end
      else
        div_reg <= div_reg + 8'h01;
      if (fall)
        bit_reg <= bit_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer: sleep, calibration, run
  // ----------------------------------------------------------------
  adcr_state_e    state_reg;
  logic [7:0]     cal_cnt_reg;
  logic [W-1:0]   off_l_reg;
  logic [W-1:0]   off_r_reg;
  logic [2*W-1:0] head;

  assign head = (cnt_reg != '0) ? buf_mem[rd_ptr_reg] : '0;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      state_reg   <= ADCR_SLEEP;
      cal_cnt_reg <= 8'h00;
    end
    else if (CE)
    begin
      unique case (state_reg)
        ADCR_SLEEP:
          if (awake && !slp_last_reg)
          begin
            state_reg   <= cal_off ? ADCR_RUN : ADCR_CAL;
            cal_cnt_reg <= 8'h00;
          end
        ADCR_CAL:
          if (!awake)
            state_reg <= ADCR_SLEEP;
          else if (frame_tick)
          begin
            cal_cnt_reg <= cal_cnt_reg + 8'h01;
            if (cal_cnt_reg == 8'(CAL_LEN - 1))
              state_reg <= ADCR_RUN;
          end
        ADCR_RUN:
          if (!awake)
            state_reg <= ADCR_SLEEP;
      endcase
    end
  end

  // Last frame of the cycle is the settled zero-input word
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      off_l_reg <= adcr_pkg::CODE_ZERO;
      off_r_reg <= adcr_pkg::CODE_ZERO;
    end
    else if (CE && state_reg == ADCR_CAL && awake && frame_tick &&
             cal_cnt_reg == 8'(CAL_LEN - 1))
    begin
      off_l_reg <= head[2*W-1:W];
      off_r_reg <= head[W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Output coding and serialiser
  // ----------------------------------------------------------------
  logic [W-1:0]            out_l;
  logic [W-1:0]            out_r;
  logic [adcr_pkg::FRAME_BITS-1:0] frame_reg;
  logic                    lrck_reg;
  logic                    sdata_reg;
  logic                    cal_reg;
  logic                    quiet;
  logic [5:0]              nbit;

  // Codes are not rescaled here, only offset-corrected; the filter scales full scale to 70000H
  assign out_l = cal_off ? head[2*W-1:W] : corr(head[2*W-1:W], off_l_reg);
  assign out_r = cal_off ? head[W-1:0]   : corr(head[W-1:0], off_r_reg);
  assign quiet = (state_reg != ADCR_RUN) || !awake;
  assign nbit  = bit_reg + 6'h01;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      frame_reg <= '0;
      lrck_reg  <= 1'b1;
      sdata_reg <= 1'b0;
      cal_reg   <= 1'b0;
    end
    else if (CE)
    begin
      cal_reg <= (state_reg == ADCR_CAL) && awake;
      if (frame_tick)
        frame_reg <= quiet ? '0 :
                     {out_l, 12'h000, out_r, 12'h000};
      if (fall)
      begin
        lrck_reg  <= (nbit < 6'(adcr_pkg::SLOT_BITS));
        if (frame_tick)
          sdata_reg <= quiet ? 1'b0 : out_l[W-1];
        else
          sdata_reg <= quiet ? 1'b0 :
                       frame_reg[adcr_pkg::FRAME_BITS - 1 - nbit];
      end
    end
  end

  // ----------------------------------------------------------------
  // Overflow hold timers, one per channel
  // ----------------------------------------------------------------
  logic [12:0] hold_l_reg;
  logic [12:0] hold_r_reg;
  logic        flag_l_reg;
  logic        flag_r_reg;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      hold_l_reg <= 13'h0000;
      hold_r_reg <= 13'h0000;
      flag_l_reg <= 1'b0;
      flag_r_reg <= 1'b0;
    end
    else if (CE && frame_tick)
    begin
      if (!quiet && clip(out_l))
        hold_l_reg <= 13'(HOLD);
      else if (hold_l_reg != 13'h0000)
        hold_l_reg <= hold_l_reg - 13'h0001;
      if (!quiet && clip(out_r))
        hold_r_reg <= 13'(HOLD);
      else if (hold_r_reg != 13'h0000)
        hold_r_reg <= hold_r_reg - 13'h0001;
      flag_l_reg <= (!quiet && clip(out_l)) || hold_l_reg > 13'h0001;
      flag_r_reg <= (!quiet && clip(out_r)) || hold_r_reg > 13'h0001;
    end
  end

  assign link.sclk            = sclk_reg;
  assign link.lrck            = lrck_reg;
  assign link.sdata           = sdata_reg;
  assign link.cal_active      = cal_reg;
  assign link.left_clip_flag  = flag_l_reg;
  assign link.right_clip_flag = flag_r_reg;
endmodule

// ### adcr_ctl.sv
// Controller end: drives the sleep/reset and calibration-disable lines,
// receives the serial words and reports status over AXI4-Lite.
// Assumes the link pins come from another domain and are resynchronised.
`timescale 1ns/100ps
module adcr_ctl #(
  parameter int HOLD_CYC = adcr_pkg::RST_HOLD_CYC
) (
  input  wire logic        MCLK,     // System clock
  input  wire logic        RST,      // Synchronous reset, active high
  input  wire logic        CE,       // Clock enable
  input  wire logic [3:0]  AWADDR,   // Write address
  input  wire logic        AWVALID,  // Write address valid
  output logic             AWREADY,  // Write address ready
  input  wire logic [31:0] WDATA,    // Write data
  input  wire logic [3:0]  WSTRB,    // Write strobes
  input  wire logic        WVALID,   // Write data valid
  output logic             WREADY,   // Write data ready
  output logic [1:0]       BRESP,    // Write response
  output logic             BVALID,   // Write response valid
  input  wire logic        BREADY,   // Write response ready
  input  wire logic [3:0]  ARADDR,   // Read address
  input  wire logic        ARVALID,  // Read address valid
  output logic             ARREADY,  // Read address ready
  output logic [31:0]      RDATA,    // Read data
  output logic [1:0]       RRESP,    // Read response
  output logic             RVALID,   // Read data valid
  input  wire logic        RREADY,   // Read data ready
  adcr_link_if.ctl         link      // Serial link to the filter end
);
  // ----------------------------------------------------------------
  // Link synchronisers
  // ----------------------------------------------------------------
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic       sclk_last_reg;
  logic       rise;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      s1_reg        <= 6'h00;
      s2_reg        <= 6'h00;
      sclk_last_reg <= 1'b0;
    end
    else if (CE)
    begin
      s1_reg <= {link.right_clip_flag, link.left_clip_flag,
                 link.cal_active, link.sdata, link.lrck, link.sclk};
      s2_reg <= s1_reg;
      sclk_last_reg <= s2_reg[0];
    end
  end
  assign rise = s2_reg[0] && !sclk_last_reg;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  logic [31:0] shr_reg;
  logic        lr_last_reg;
  logic [19:0] left_reg;
  logic [19:0] right_reg;
  logic        new_set;

  assign new_set = CE && rise && (s2_reg[1] != lr_last_reg) && s2_reg[1];

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      shr_reg     <= 32'h00000000;
      lr_last_reg <= 1'b1;
      left_reg    <= 20'h00000;
      right_reg   <= 20'h00000;
    end
    else if (CE && rise)
    begin
      shr_reg     <= {shr_reg[30:0], s2_reg[2]};
      lr_last_reg <= s2_reg[1];
      if (s2_reg[1] != lr_last_reg)
      begin
        if (lr_last_reg)
          left_reg <= shr_reg[31:12];
        else
          right_reg <= shr_reg[31:12];
      end
    end
  end

  // ----------------------------------------------------------------
  // Control lines and timed reset pulse
  // ----------------------------------------------------------------
  logic        sleep_reg;
  logic        caloff_reg;
  logic [15:0] hold_reg;
  logic        pin_n_reg;
  logic        new_reg;
  logic        wr_go;
  logic [3:0]  aw_reg;
  logic [31:0] w_reg;
  logic        aw_ok_reg;
  logic        w_ok_reg;

  assign wr_go = aw_ok_reg && w_ok_reg && !BVALID;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      sleep_reg  <= CTRL_RESET_BIT(0);
      caloff_reg <= CTRL_RESET_BIT(1);
      hold_reg   <= 16'(HOLD_CYC);           // Power-on pulse
      pin_n_reg  <= 1'b0;
      new_reg    <= 1'b0;
    end
    else if (CE)
    begin
      if (wr_go && aw_reg == adcr_pkg::REG_CTRL)
      begin
        sleep_reg  <= w_reg[adcr_pkg::CTRL_SLEEP];
        caloff_reg <= w_reg[adcr_pkg::CTRL_CALOFF];
      end
      // Pulse longer than two sample periods, then release
      if (wr_go && aw_reg == adcr_pkg::REG_CTRL &&
          w_reg[adcr_pkg::CTRL_PULSE])
        hold_reg <= 16'(HOLD_CYC);
      else if (hold_reg != 16'h0000)
        hold_reg <= hold_reg - 16'h0001;
      pin_n_reg <= !sleep_reg && (hold_reg == 16'h0000);
      // New pair wins over a clear in the same cycle
      if (new_set)
        new_reg <= 1'b1;
      else if (wr_go && aw_reg == adcr_pkg::REG_STATUS &&
               w_reg[adcr_pkg::ST_NEW])
        new_reg <= 1'b0;
    end
  end

  function automatic logic CTRL_RESET_BIT(input int i);
    CTRL_RESET_BIT = adcr_pkg::CTRL_RESET[i];
  endfunction

  assign link.sleep_reset_n_in         = pin_n_reg;
  assign link.offset_correction_off_in = caloff_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      AWREADY   <= 1'b0;
      WREADY    <= 1'b0;
      aw_ok_reg <= 1'b0;
      w_ok_reg  <= 1'b0;
      aw_reg    <= 4'h0;
      w_reg     <= 32'h00000000;
      BVALID    <= 1'b0;
      BRESP     <= adcr_pkg::RESP_OKAY;
    end
    else if (CE)
    begin
      AWREADY <= !aw_ok_reg && !AWREADY && AWVALID;
      WREADY  <= !w_ok_reg && !WREADY && WVALID;
      if (AWVALID && AWREADY)
      begin
        aw_ok_reg <= 1'b1;
        aw_reg    <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_ok_reg <= 1'b1;
        w_reg    <= WDATA;
      end
      if (wr_go)
      begin
        aw_ok_reg <= 1'b0;
        w_ok_reg  <= 1'b0;
        BVALID    <= 1'b1;
        BRESP     <= (aw_reg[1:0] == 2'h0 && (aw_reg == adcr_pkg::REG_CTRL ||
                      aw_reg == adcr_pkg::REG_STATUS)) ?
                     adcr_pkg::RESP_OKAY : adcr_pkg::RESP_SLV;
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      ARREADY <= 1'b0;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= adcr_pkg::RESP_OKAY;
    end
    else if (CE)
    begin
      ARREADY <= !RVALID && !ARREADY && ARVALID;
      if (ARVALID && ARREADY)
      begin
        RVALID <= 1'b1;
        RRESP  <= adcr_pkg::RESP_OKAY;
        unique case (ARADDR)
          adcr_pkg::REG_CTRL:   RDATA <= {29'h0, 1'b0, caloff_reg, sleep_reg};
          adcr_pkg::REG_STATUS: RDATA <= {27'h0, new_reg,
                                          hold_reg != 16'h0000,
                                          s2_reg[5], s2_reg[4], s2_reg[3]};
          adcr_pkg::REG_LEFT:   RDATA <= {{12{left_reg[19]}}, left_reg};
          adcr_pkg::REG_RIGHT:  RDATA <= {{12{right_reg[19]}}, right_reg};
          default:
          begin
            RDATA <= 32'h00000000;
            RRESP <= adcr_pkg::RESP_SLV;
          end
        endcase
      end
      else if (RVALID && RREADY)
        RVALID <= 1'b0;
    end
  end
endmodule

// ### adcr_link_assertions.sv
// Checker of the serial link between the two converter ends.
// Assumes it sees the interface signals directly, with no bind.
`timescale 1ns/100ps
module adcr_link_assertions #(
  parameter int HOLD = 8,                   // Clip hold, frames
  parameter int CAL  = 4                    // Calibration, frames
) (
  input wire logic MCLK,                    // Clock
  input wire logic RST,                     // Reset
  input wire logic sclk,                    // Bit clock
  input wire logic lrck,                    // Slot select
  input wire logic sdata,                   // Serial data
  input wire logic cal_active,              // Calibrating
  input wire logic left_clip_flag,          // Left clip
  input wire logic right_clip_flag,         // Right clip
  input wire logic sleep_reset_n_in,        // Sleep, low
  input wire logic offset_correction_off_in // No correction
);
  localparam int FR = 2 * adcr_pkg::SCLK_HALF * adcr_pkg::FRAME_BITS;
  int lcnt, rcnt, ccnt, scnt;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // ----
  // Run lengths of the held levels
  // ----
  always_ff @(posedge MCLK)
  begin
    lcnt <= (RST || !left_clip_flag) ? 0 : lcnt + 1;
    rcnt <= (RST || !right_clip_flag) ? 0 : rcnt + 1;
    ccnt <= (RST || !cal_active) ? 0 : ccnt + 1;
    scnt <= (RST || sleep_reset_n_in) ? 0 : scnt + 1;
  end
  a_cal_quiet: assert property (cal_active |-> !sdata)
    else $error("data high while calibrating");
  a_cal_start: assert property ($rose(cal_active) |->
    sleep_reset_n_in && !offset_correction_off_in)
    else $error("calibration started without release");
  a_cal_span: assert property ($fell(cal_active) |->
    ccnt > (CAL - 1) * FR) else $error("calibration too short");
  a_cal_bound: assert property (cal_active |->
    ccnt <= CAL * FR + FR) else $error("calibration too long");
  a_lclip_hold: assert property ($fell(left_clip_flag) |->
    lcnt >= HOLD * FR - 16) else $error("left clip flag short");
  a_rclip_hold: assert property ($fell(right_clip_flag) |->
    rcnt >= HOLD * FR - 16) else $error("right clip flag short");
  a_slot_edge: assert property ($changed(lrck) &&
    $past(sleep_reset_n_in, 5) && $past(sleep_reset_n_in) |-> $fell(sclk))
    else $error("slot change off the bit clock fall");
  a_rst_state: assert property ($fell(RST) |-> !cal_active &&
    !left_clip_flag && !right_clip_flag && !sleep_reset_n_in)
    else $error("link not idle after reset");
  a_rst_hold: assert property ($rose(sleep_reset_n_in) |->
    scnt > 2 * FR) else $error("sleep/reset pulse too short");
  c_cal: cover property ($rose(cal_active));
  c_lclip: cover property ($rose(left_clip_flag));
  c_rclip: cover property ($rose(right_clip_flag));
endmodule

// ### tb.sv
// Bench: both converter ends joined by the link, steered over AXI4-Lite.
// Assumes CE stays high; one xorshift stream gives all random codes.
`timescale 1ns/100ps
module tb;
  localparam int FR   = 2 * adcr_pkg::SCLK_HALF * adcr_pkg::FRAME_BITS;
  localparam int HOLD = 8;
  logic        MCLK, RST, CE, IN_VALID, IN_READY, corr;
  logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic        ARVALID, ARREADY, RVALID, RREADY;
  logic [1:0]  BRESP, RRESP;
  logic [3:0]  AWADDR, WSTRB, ARADDR;
  logic [19:0] IN_LEFT, IN_RIGHT, off_l, off_r;
  logic [31:0] WDATA, RDATA, rd, seed;
  logic [19:0] tbl [4];
  int          err_count, check_count;
  adcr_link_if link ();
  adcr_dev #(.HOLD(HOLD)) i_adcr_dev (.MCLK(MCLK), .RST(RST), .CE(CE),
    .IN_LEFT(IN_LEFT), .IN_RIGHT(IN_RIGHT), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .link(link));
  adcr_ctl i_adcr_ctl (.MCLK(MCLK), .RST(RST), .CE(CE),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .link(link));
  adcr_link_assertions #(.HOLD(HOLD), .CAL(adcr_pkg::CAL_FRAMES))
    i_adcr_link_assertions (.MCLK(MCLK), .RST(RST), .sclk(link.sclk),
    .lrck(link.lrck), .sdata(link.sdata), .cal_active(link.cal_active),
    .left_clip_flag(link.left_clip_flag),
    .right_clip_flag(link.right_clip_flag),
    .sleep_reset_n_in(link.sleep_reset_n_in),
    .offset_correction_off_in(link.offset_correction_off_in));
  // ----
  // Helpers
  // ----
  function automatic logic [19:0] sx(input int b);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return 20'($signed(seed << (32 - b)) >>> (32 - b));
  endfunction
  // Offset removed with saturation, only while correction is on
  function automatic logic [31:0] expv(input logic [19:0] v, o);
    logic signed [20:0] d;
    d = $signed({v[19], v}) - (corr ? $signed({o[19], o}) : 21'sh0);
    if (d > 21'sh07FFFF) d = 21'sh07FFFF;
    if (d < -21'sh080000) d = -21'sh080000;
    return {{12{d[19]}}, d[19:0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, s);
    check_count++;
    if (s !== e)
    begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      err_count++;
    end
  endtask
  task automatic frames(input int n);
    repeat (n * FR) @(posedge MCLK);
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, b;
    {aw, w, b} = 3'h7;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    while (b)
    begin
      {AWVALID, WVALID, BREADY} <= {aw, w, b};
      @(posedge MCLK);
      aw = aw && !AWREADY;
      w = w && !WREADY;
      b = aw || w || !BVALID;
    end
    {AWVALID, WVALID, BREADY} <= 3'h0;
  endtask
  task automatic axr(input logic [3:0] a, output logic [31:0] d);
    logic ar, r;
    {ar, r} = 2'h3;
    @(posedge MCLK);
    ARADDR <= a;
    while (r)
    begin
      {ARVALID, RREADY} <= {ar, r};
      @(posedge MCLK);
      ar = ar && !ARREADY;
      r = ar || !RVALID;
      d = RDATA;
    end
    {ARVALID, RREADY} <= 2'h0;
  endtask
  // Payload changes only right after the edge that took it
  task automatic put(input logic [19:0] l, r);
    @(posedge MCLK);
    while (IN_READY !== 1'h1) @(posedge MCLK);
    IN_LEFT <= l;
    IN_RIGHT <= r;
  endtask
  task automatic pair_check(input logic [19:0] l, r);
    put(l, r);
    frames(6);
    axr(adcr_pkg::REG_LEFT, rd);
    chk("left word", expv(l, off_l), rd);
    axr(adcr_pkg::REG_RIGHT, rd);
    chk("right word", expv(r, off_r), rd);
  endtask
  task automatic wait_cal();
    int n, t;
    n = 0;
    while (link.cal_active !== 1'h1 && n < 4000)
    begin
      @(posedge MCLK);
      n++;
    end
    t = n;
    while (link.cal_active !== 1'h0 && n < 9000)
    begin
      @(posedge MCLK);
      n++;
    end
    chk("cal length", 32'(n - t > 3 * FR && n - t <= 4 * FR), 32'h1);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    MCLK = 1'h0;
    forever #20 MCLK = ~MCLK;
  end
  initial
  begin
    repeat (80000) @(posedge MCLK);
    err_count++;
    report_and_stop();
  end
  initial
  begin
    {seed, corr, RST, CE} = {32'h1AA5, 3'h7};
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, IN_VALID} = 6'h0;
    {AWADDR, ARADDR, WDATA, WSTRB} = {40'h0, 4'hF};
    off_l = sx(12);
    off_r = sx(12);
    {IN_LEFT, IN_RIGHT} = {off_l, off_r};
    repeat (10) @(posedge MCLK);
    RST <= 1'h0;
    IN_VALID <= 1'h1;
    wait_cal();
    repeat (4) pair_check(sx(18), sx(18));
    $display("test correction done");
    off_l = 20'hFFF00;
    off_r = sx(12);
    put(off_l, off_r);
    axw(adcr_pkg::REG_CTRL, 32'h4);
    wait_cal();
    pair_check(20'h7FFFF, 20'h0);
    chk("left clip", 32'h1, 32'(link.left_clip_flag));
    chk("right clip", 32'h0, 32'(link.right_clip_flag));
    pair_check(20'h01000, 20'h81000);
    chk("right clip", 32'h1, 32'(link.right_clip_flag));
    put(20'h0, 20'h0);
    frames(HOLD + 6);
    chk("left end", 32'h0, 32'(link.left_clip_flag));
    chk("right end", 32'h0, 32'(link.right_clip_flag));
    $display("test clip done");
    axw(adcr_pkg::REG_CTRL, 32'h1);
    frames(3);
    axr(adcr_pkg::REG_LEFT, rd);
    chk("sleep word", 32'h0, rd);
    corr = 1'h0;
    axw(adcr_pkg::REG_CTRL, 32'h2);
    frames(2);
    chk("no cal", 32'h0, 32'(link.cal_active));
    tbl = '{20'h70000, 20'h90000, 20'h7FFFF, 20'h80000};
    foreach (tbl[i]) pair_check(tbl[i], sx(18));
    axr(adcr_pkg::REG_CTRL, rd);
    chk("control", 32'h2, rd);
    $display("test bypass done");
    report_and_stop();
  end
endmodule
